// File: hdl/dsa_pkg.sv
// Constants shared by the display signature analyzer files.
// Assumes a 32-bit register port with byte addresses on word boundaries.

package dsa_pkg;

	// ******************************************************************
	// Register map.
	// ******************************************************************
	localparam logic [7:0] DSA_CTRL_OFFSET   = 8'h64;
	localparam logic [7:0] DSA_STATUS_OFFSET = 8'h70;
	localparam logic [7:0] DSA_MASK_OFFSET   = 8'h74;

	// ******************************************************************
	// Field positions of the control and status register.
	// ******************************************************************
	localparam int DSA_SIG_LSB   = 16;
	localparam int DSA_RUN_BIT   = 3;
	localparam int DSA_CLEAR_BIT = 2;
	localparam int DSA_SEL_MSB   = 1;

	// ******************************************************************
	// Event bits of the status and mask registers.
	// ******************************************************************
	localparam int DSA_EVT_DONE    = 0;
	localparam int DSA_EVT_CLEARED = 1;
	localparam int DSA_EVT_WIDTH   = 2;

	// ******************************************************************
	// Reset values and signature feedback.
	// ******************************************************************
	localparam logic [15:0] DSA_SIG_RESET   = 16'h0000;
	localparam logic [1:0]  DSA_SEL_RESET   = 2'h0;
	localparam logic [1:0]  DSA_EVT_RESET   = 2'h0;
	localparam logic [31:0] DSA_RDATA_RESET = 32'h00000000;
	localparam logic [15:0] DSA_SIG_POLY    = 16'h1021;

	// ******************************************************************
	// Channel select codes.
	// ******************************************************************
	localparam logic [1:0] DSA_SEL_RED   = 2'h0;
	localparam logic [1:0] DSA_SEL_GREEN = 2'h1;

	typedef enum logic [1:0] {
		DSA_IDLE,
		DSA_ARM,
		DSA_ACCUM
	} dsa_state_type;

endpackage

// File: hdl/dsa_sig_step.sv
// One step of the 16-bit signature feedback shift register.
// Assumes a pixel byte from the same clock domain; purely combinational.

`timescale 1ns/1ps
`default_nettype none

module dsa_sig_step
	import dsa_pkg::*;
(
	input  wire logic [15:0] sigIn,
	input  wire logic [7:0]  pixel,
	output logic      [15:0] sigOut
);

	// ******************************************************************
	// Shift with polynomial feedback, then fold in the pixel byte.
	// ******************************************************************
	always_comb begin
		sigOut = {sigIn[14:0], 1'b0} ^ {8'h00, pixel};
		if (sigIn[15]) begin
			sigOut = sigOut ^ DSA_SIG_POLY;
		end
	end

endmodule

`default_nettype wire

// File: hdl/dsa_signature_analyzer.sv
// Display signature analyzer: register port, frame sequencer, signature.
// Assumes pixel data, display enable and vertical sync come from logic on
// the pixel clock, so none of them is synchronised here.
//
// The implementer's own choice: the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Signature readable in bits 31:16, writes ignored.
// - Run reads 1 busy; hardware clears when done.
// - Clear bit 2 forces signature to zero.
// - Run and clear set: clear drops at vsync.
// - Select 00 red, 01 green, 1x blue.
module dsa_signature_analyzer
	import dsa_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	output logic             irq,
	input  wire logic [7:0]  pixRed,
	input  wire logic [7:0]  pixGreen,
	input  wire logic [7:0]  pixBlue,
	input  wire logic        displayActive,
	input  wire logic        vsync
);

	// ******************************************************************
	// State.
	// ******************************************************************
	dsa_state_type     state_ff;
	dsa_state_type     nxt_state;
	logic              runFlag_ff;
	logic              nxt_runFlag;
	logic              clearFlag_ff;
	logic              nxt_clearFlag;
	logic [1:0]        chanSel_ff;
	logic [1:0]        nxt_chanSel;
	logic [15:0]       sig_ff;
	logic [15:0]       nxt_sig;
	logic              vsyncPrev_ff;
	logic              nxt_vsyncPrev;
	logic [1:0]        evtStatus_ff;
	logic [1:0]        nxt_evtStatus;
	logic [1:0]        evtMask_ff;
	logic [1:0]        nxt_evtMask;
	logic [31:0]       rdata_ff;
	logic [31:0]       nxt_rdata;
	logic              irq_ff;
	logic              nxt_irq;
	logic [7:0]        pixSel;
	logic [15:0]       sigStep;
	logic              vsyncRise;
	logic              ctrlWr;
	logic [1:0]        evtSet;

	assign vsyncRise = vsync & ~vsyncPrev_ff;
	assign ctrlWr    = regWr && (regAddr == DSA_CTRL_OFFSET);
	assign regRdata  = rdata_ff;
	assign irq       = irq_ff;

	// ******************************************************************
	// Channel selection and signature step.
	// ******************************************************************
	always_comb begin
		if (chanSel_ff[DSA_SEL_MSB]) begin
			pixSel = pixBlue;
		end else if (chanSel_ff == DSA_SEL_GREEN) begin
			pixSel = pixGreen;
		end else begin
			pixSel = pixRed;
		end
	end

	dsa_sig_step u_step (
		.sigIn  (sig_ff),
		.pixel  (pixSel),
		.sigOut (sigStep)
	);

	// ******************************************************************
	// Frame sequencer and control bits.
	// ******************************************************************
	always_comb begin
		nxt_state     = state_ff;
		nxt_runFlag   = runFlag_ff;
		nxt_clearFlag = clearFlag_ff;
		nxt_chanSel   = chanSel_ff;
		nxt_sig       = sig_ff;
		nxt_vsyncPrev = vsync;
		evtSet        = DSA_EVT_RESET;
		case (state_ff)
			DSA_IDLE: begin
				if (runFlag_ff) begin
					nxt_state = DSA_ARM;
				end
			end
			DSA_ARM: begin
				// A frame starts only on a vsync edge so that a whole frame
				// is always compressed, never a partial one.
				if (vsyncRise) begin
					nxt_state = DSA_ACCUM;
					if (clearFlag_ff) begin
						nxt_clearFlag = 1'b0;
						evtSet[DSA_EVT_CLEARED] = 1'b1;
					end
				end
			end
			DSA_ACCUM: begin
				// A clear raised mid-frame has already zeroed the partial
				// signature, so its vsync opens a fresh frame instead.
				if (vsyncRise && clearFlag_ff) begin
					nxt_clearFlag = 1'b0;
					evtSet[DSA_EVT_CLEARED] = 1'b1;
				end else if (vsyncRise) begin
					nxt_state   = DSA_IDLE;
					nxt_runFlag = 1'b0;
					evtSet[DSA_EVT_DONE] = 1'b1;
				end else if (displayActive) begin
					nxt_sig = sigStep;
				end
			end
			default: begin
				nxt_state = DSA_IDLE;
			end
		endcase
		if (!runFlag_ff) begin
			nxt_state = DSA_IDLE;
		end
		// A software write in the same cycle as a hardware update wins,
		// so a restart issued at frame end is never lost.
		if (ctrlWr) begin
			nxt_runFlag   = regWdata[DSA_RUN_BIT];
			nxt_clearFlag = regWdata[DSA_CLEAR_BIT];
			nxt_chanSel   = regWdata[DSA_SEL_MSB:0];
		end
		if (clearFlag_ff) begin
			nxt_sig = DSA_SIG_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff     <= DSA_IDLE;
			runFlag_ff   <= 1'b0;
			clearFlag_ff <= 1'b0;
			chanSel_ff   <= DSA_SEL_RESET;
			sig_ff       <= DSA_SIG_RESET;
			vsyncPrev_ff <= 1'b0;
		end else if (ce) begin
			state_ff     <= nxt_state;
			runFlag_ff   <= nxt_runFlag;
			clearFlag_ff <= nxt_clearFlag;
			chanSel_ff   <= nxt_chanSel;
			sig_ff       <= nxt_sig;
			vsyncPrev_ff <= nxt_vsyncPrev;
		end
	end

	// ******************************************************************
	// Register port and interrupt.
	// ******************************************************************
	// Read data stand for one cycle and are zero otherwise, so several
	// blocks can share one or-ed return path without a multiplexer.
	always_comb begin
		nxt_evtMask   = evtMask_ff;
		nxt_evtStatus = evtStatus_ff;
		nxt_rdata     = DSA_RDATA_RESET;
		if (regWr && (regAddr == DSA_STATUS_OFFSET)) begin
			nxt_evtStatus = evtStatus_ff & ~regWdata[DSA_EVT_WIDTH-1:0];
		end
		if (regWr && (regAddr == DSA_MASK_OFFSET)) begin
			nxt_evtMask = regWdata[DSA_EVT_WIDTH-1:0];
		end
		// Setting after clearing lets a new event win over a clear.
		nxt_evtStatus = nxt_evtStatus | evtSet;
		if (regRd) begin
			case (regAddr)
				DSA_CTRL_OFFSET: begin
					nxt_rdata[31:DSA_SIG_LSB]  = sig_ff;
					nxt_rdata[DSA_RUN_BIT]     = runFlag_ff;
					nxt_rdata[DSA_CLEAR_BIT]   = clearFlag_ff;
					nxt_rdata[DSA_SEL_MSB:0]   = chanSel_ff;
				end
				DSA_STATUS_OFFSET: begin
					nxt_rdata[DSA_EVT_WIDTH-1:0] = evtStatus_ff;
				end
				DSA_MASK_OFFSET: begin
					nxt_rdata[DSA_EVT_WIDTH-1:0] = evtMask_ff;
				end
				default: begin
					nxt_rdata = DSA_RDATA_RESET;
				end
			endcase
		end
		nxt_irq = |(nxt_evtStatus & nxt_evtMask);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			evtStatus_ff <= DSA_EVT_RESET;
			evtMask_ff   <= DSA_EVT_RESET;
			rdata_ff     <= DSA_RDATA_RESET;
			irq_ff       <= 1'b0;
		end else if (ce) begin
			evtStatus_ff <= nxt_evtStatus;
			evtMask_ff   <= nxt_evtMask;
			rdata_ff     <= nxt_rdata;
			irq_ff       <= nxt_irq;
		end
	end

endmodule

`default_nettype wire

// File: dv/dsa_checker.sv
// Checker for the signature analyzer register port and interrupt.
// Assumes the bind below attaches it to the top; a low ce pauses checks.
`timescale 1ns/1ps
`default_nettype none
module dsa_checker
	import dsa_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic        irq,
	input wire logic        displayActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst || !ce);
	sequence s_wrc; regWr && regAddr == DSA_CTRL_OFFSET; endsequence
	sequence s_rdc; regRd && regAddr == DSA_CTRL_OFFSET; endsequence
	sequence s_rdq; s_rdc ##0 !displayActive; endsequence
	sequence s_gap; !regWr && !displayActive; endsequence
	property p_resv; s_rdc |=> regRdata[15:4] == 12'h000; endproperty
	property p_idle; !regRd |=> regRdata == 32'h0; endproperty
	property p_unmap; regRd && regAddr == 8'h00 |=> regRdata == 32'h0;
	endproperty
	property p_stable;
		!regWr ##1 s_rdq ##1 s_gap ##1 s_rdc |=>
			regRdata[31:16] == $past(regRdata[31:16], 2);
	endproperty
	property p_sel;
		s_wrc ##1 !regWr ##1 s_rdc |=>
			regRdata[1:0] == $past(regWdata[1:0], 3);
	endproperty
	property p_clr;
		(s_wrc ##0 regWdata[2]) ##1 !regWr ##1 s_rdc |=>
			regRdata[31:16] == 16'h0000;
	endproperty
	property p_run0;
		(s_wrc ##0 regWdata[3:2] == 2'h0) ##1 !regWr ##1 s_rdc |=>
			regRdata[3:2] == 2'h0;
	endproperty
	property p_irq;
		regWr && regAddr == DSA_MASK_OFFSET && regWdata[1:0] == 2'h0
			##1 !regWr |=> ##1 !irq;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	a_idle: assert property (p_idle) else $error("stray read data");
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	a_stable: assert property (p_stable) else $error("sig drift");
	a_sel: assert property (p_sel) else $error("select lost");
	a_clr: assert property (p_clr) else $error("sig not cleared");
	a_run0: assert property (p_run0) else $error("run stuck");
	a_irq: assert property (p_irq) else $error("masked irq");
endmodule
bind dsa_signature_analyzer dsa_checker u_chk (.clk(clk), .nrst(nrst),
	.ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .irq(irq),
	.displayActive(displayActive));
`default_nettype wire

// File: dv/dsa_signature_analyzer_tb.sv
// Self-checking bench for the display signature analyzer.
// Assumes the analyzer is alone on the register port and ce is driven here.
`timescale 1ns/1ps
`default_nettype none
module dsa_signature_analyzer_tb
	import dsa_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic        displayActive = 1'b0;
	logic        vsync = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  pixRed = 8'h00;
	logic [7:0]  pixGreen = 8'h00;
	logic [7:0]  pixBlue = 8'h00;
	logic [31:0] regRdata;
	logic        irq;
	logic [15:0] sig = 16'h0000;
	int          nMismatch = 0;
	int          totalChecks = 0;
	int          cyc = 0;
	dsa_signature_analyzer uut (.clk(clk), .nrst(nrst), .ce(ce),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .irq(irq), .pixRed(pixRed),
		.pixGreen(pixGreen), .pixBlue(pixBlue),
		.displayActive(displayActive), .vsync(vsync));
	initial forever #20 clk = ~clk;
	task automatic test_done;
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdata, exp);
	endtask
	task automatic vpulse;
		@(posedge clk);
		vsync <= 1'b1;
		@(posedge clk);
		vsync <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// The clear write must wipe the previous frame's signature.
	task automatic run_frame(logic [1:0] sel);
		logic [7:0] p;
		wr(DSA_CTRL_OFFSET, {28'h0, 2'h3, sel});
		rd(DSA_CTRL_OFFSET, {28'h0, 2'h3, sel});
		vpulse();
		rd(DSA_CTRL_OFFSET, {28'h0, 2'h2, sel});
		sig = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			p = 8'(i) * 8'h25;
			displayActive <= 1'b1;
			pixRed <= p;
			pixGreen <= p ^ 8'h5A;
			pixBlue <= p ^ 8'hC3;
			p = sel[1] ? p ^ 8'hC3 : sel[0] ? p ^ 8'h5A : p;
			sig = {sig[14:0], 1'b0} ^ {8'h00, p}
				^ (sig[15] ? DSA_SIG_POLY : 16'h0000);
		end
		@(posedge clk);
		displayActive <= 1'b0;
		vpulse();
		#1 chk({31'h0, irq}, 32'h1);
		rd(DSA_CTRL_OFFSET, {sig, 12'h000, 2'h0, sel});
		rd(DSA_STATUS_OFFSET, 32'h3);
		wr(DSA_STATUS_OFFSET, 32'h3);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h0);
	endtask
	// Masking a pending event must drop the interrupt at once.
	task automatic test_mask;
		wr(DSA_CTRL_OFFSET, 32'h00000008);
		vpulse();
		vpulse();
		#1 chk({31'h0, irq}, 32'h1);
		wr(DSA_MASK_OFFSET, 32'h0);
		#1 chk({31'h0, irq}, 32'h0);
		repeat (3) @(posedge clk);
		wr(DSA_MASK_OFFSET, 32'h1);
		#1 chk({31'h0, irq}, 32'h1);
		rd(DSA_CTRL_OFFSET, {sig, 16'h0000});
	endtask
	// A reset after a finished run returns every register and the interrupt to zero.
	task automatic test_reset;
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1 chk({31'h0, irq}, 32'h0);
		rd(DSA_CTRL_OFFSET, 32'h0);
		rd(DSA_STATUS_OFFSET, 32'h0);
		rd(DSA_MASK_OFFSET, 32'h0);
	endtask
	// With the clock enable low no write may be taken.
	task automatic test_ce;
		@(posedge clk);
		ce <= 1'b0;
		wr(DSA_CTRL_OFFSET, 32'h0000000F);
		wr(DSA_MASK_OFFSET, 32'h00000003);
		@(posedge clk);
		ce <= 1'b1;
		rd(DSA_CTRL_OFFSET, 32'h0);
		rd(DSA_MASK_OFFSET, 32'h0);
	endtask
	// Raising clear in mid-frame restarts the frame at the next vsync.
	task automatic test_restart;
		wr(DSA_CTRL_OFFSET, 32'h00000008);
		vpulse();
		@(posedge clk);
		displayActive <= 1'b1;
		pixRed <= 8'h5A;
		@(posedge clk);
		displayActive <= 1'b0;
		rd(DSA_CTRL_OFFSET, 32'h005A0008);
		wr(DSA_CTRL_OFFSET, 32'h0000000C);
		rd(DSA_CTRL_OFFSET, 32'h0000000C);
		vpulse();
		rd(DSA_CTRL_OFFSET, 32'h00000008);
		vpulse();
		rd(DSA_CTRL_OFFSET, 32'h00000000);
		rd(DSA_STATUS_OFFSET, 32'h00000003);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			nMismatch++;
			test_done();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rd(DSA_CTRL_OFFSET, 32'h0);
		rd(DSA_STATUS_OFFSET, 32'h0);
		rd(8'h00, 32'h0);
		wr(DSA_MASK_OFFSET, 32'h1);
		for (int s = 0; s < 4; s++)
			run_frame(2'(s));
		wr(DSA_CTRL_OFFSET, 32'hA5A50003);
		rd(DSA_CTRL_OFFSET, {sig, 16'h0003});
		rd(DSA_CTRL_OFFSET, {sig, 16'h0003});
		test_mask();
		test_reset();
		test_ce();
		test_restart();
		test_done();
	end
endmodule
`default_nettype wire
